// file: common/pcfg_map.vh
// register offsets, field positions and reset values of the configuration header bank
`ifndef PCFG_MAP_VH
`define PCFG_MAP_VH
`define PCFG_OFS_LAT_LINE    8'h0C
`define PCFG_OFS_IO_BASE     8'h10
`define PCFG_OFS_MEM_BASE    8'h14
`define PCFG_OFS_SUBSYS      8'h2C
`define PCFG_OFS_ROM_BASE    8'h30
`define PCFG_OFS_MASTER_STAT 8'h40
`define PCFG_RST_HOLD_TIMER  8'h40
`define PCFG_RST_LINE_WORDS  8'h08
`define PCFG_LINE_8          8'h08
`define PCFG_LINE_16         8'h10
`define PCFG_LINE_32         8'h20
`define PCFG_WIN_BASE_LSB    7
`define PCFG_ROM_BASE_LSB    17
`define PCFG_EE_LOAD_CYC     16'h0040
`endif

// file: logic/pcfg_header_regs.v
// configuration header registers: latency/line size, windows, subsystem id, boot rom
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`include "pcfg_map.vh"
// Summary of operation
// - latency timer, reset 40h, starts at frame
// - expired timer ends transaction when grant removed
// - cache line words, reset 08h, 8/16/32
// - io base bits 31..7, reset zero
// - io base bit 0 reads one
// - memory base bits 31..7, reset zero
// - subsystem id loaded from eeprom after reset release
// - subsystem vendor id loaded from eeprom
// - timer and line size read/write
module pcfg_header_regs #(
   parameter EE_LOAD_CYC = `PCFG_EE_LOAD_CYC   // cycles until eeprom word is valid
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire [7:0]  avs_address_i,     // byte address
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output wire        avs_waitrequest_o,
   output reg  [31:0] avs_readdata_o,
   input  wire [31:0] ee_subsys_i,       // eeprom word: id high, vendor low
   input  wire        frame_start_i,     // pulse from master engine
   input  wire        frame_active_i,    // level from master engine
   input  wire        gnt_n_i,           // bus grant pin, active low
   output wire [7:0]  cache_line_words_o,
   output wire        cache_line_ok_o,   // line size is a supported value
   output wire [24:0] io_window_base_addr_o,
   output wire [24:0] memory_window_base_addr_o,
   output wire [14:0] boot_rom_base_addr_o,
   output wire        boot_rom_en_o,
   output wire        bus_hold_expired_o,
   output wire        end_txn_o
);
   // stored fields
   reg  [7:0]  hold_timer_ff;            // bus_hold_timer
   reg  [7:0]  line_words_ff;            // cache_line_words
   reg  [24:0] io_base_ff;
   reg  [24:0] mem_base_ff;
   reg  [14:0] rom_base_ff;
   reg         rom_en_ff;
   reg  [15:0] sub_id_ff;                // subsystem_ident
   reg  [15:0] sub_vid_ff;               // subsystem_vendor_ident
   reg  [15:0] ee_cnt_ff;                // eeprom load counter, counts up
   reg         ee_done_ff;
   reg         ack_ff;                   // one-cycle answer
   reg         gnt_s1_ff;                // grant synchroniser stage 1
   reg         gnt_s2_ff;
   reg  [31:0] nxt_rdata;

   // next values of the stored fields
   reg  [7:0]  nxt_hold_timer;
   reg  [7:0]  nxt_line_words;
   reg  [24:0] nxt_io_base;
   reg  [24:0] nxt_mem_base;
   reg  [14:0] nxt_rom_base;
   reg         nxt_rom_en;
   reg  [15:0] nxt_ee_cnt;
   reg         nxt_ee_done;
   reg  [15:0] nxt_sub_id;
   reg  [15:0] nxt_sub_vid;
   reg         line_ok;                  // line size is a supported value

   // bus handshake
   wire        req;
   wire        wr_en;
   wire [31:0] be_mask;
   // register selects and read images
   wire        hit_lat;
   wire        hit_io;
   wire        hit_mem;
   wire        hit_rom;
   wire [31:0] lat_view;
   wire [31:0] io_view;
   wire [31:0] mem_view;
   wire [31:0] sub_view;
   wire [31:0] rom_view;
   wire [31:0] stat_view;

   // bus timing as the master sees it:
   //   edge 0: read or write raised with address, data and lanes
   //   edge 1: read image captured, acknowledge flop set
   //   edge 2: waitrequest sampled low; write lands, read data taken
   // every transfer costs exactly one wait cycle, whatever the address;
   // a new request may be raised at edge 2 itself
   // any request, read or write
   assign req = avs_read_i | avs_write_i;
   // one wait cycle: answer on the edge after request is seen
   assign avs_waitrequest_o = req & ~ack_ff;
   // writes land on the edge where waitrequest is sampled low; the master
   // still holds address, data and lanes there
   assign wr_en = avs_write_i & ack_ff;
   // byte lanes widened to bit masks
   assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // address decode, one select per writable register
   assign hit_lat = (avs_address_i == `PCFG_OFS_LAT_LINE);
   assign hit_io  = (avs_address_i == `PCFG_OFS_IO_BASE);
   assign hit_mem = (avs_address_i == `PCFG_OFS_MEM_BASE);
   assign hit_rom = (avs_address_i == `PCFG_OFS_ROM_BASE);

   // acknowledge pulse: set on the edge after a request appears and
   // cleared on the next, so each transfer is answered once;
   // a master that keeps its request up after the answer
   // starts a fresh transfer
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // grant pin crosses in through two flops; both start at the idle,
   // not-granted level of the pin; the price is two cycles of lag
   // before a withdrawn grant is seen by the timer
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gnt_s1_ff <= 1'b1;
         gnt_s2_ff <= 1'b1;
      end else begin
         gnt_s1_ff <= gnt_n_i;
         gnt_s2_ff <= gnt_s1_ff;
      end
   end

   // eeprom identity: the loader needs EE_LOAD_CYC edges after reset
   // release before its word settles, so nothing is taken under reset;
   // every reset clears the fields and starts a fresh load
   always @* begin
      nxt_ee_cnt  = ee_cnt_ff;
      nxt_ee_done = ee_done_ff;
      nxt_sub_id  = sub_id_ff;
      nxt_sub_vid = sub_vid_ff;
      // count edges until the loader word settles, then freeze
      if (!ee_done_ff) begin
         if (ee_cnt_ff == EE_LOAD_CYC[15:0]) begin
            // capture once; held until the next reset
            nxt_sub_id  = ee_subsys_i[31:16];
            nxt_sub_vid = ee_subsys_i[15:0];
            nxt_ee_done = 1'b1;
         end else begin
            nxt_ee_cnt = ee_cnt_ff + 16'h0001;
         end
      end
   end

   // identity flops; cleared by reset so software never reads a stale word
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ee_cnt_ff  <= 16'h0000;
         ee_done_ff <= 1'b0;
         sub_id_ff  <= 16'h0000;
         sub_vid_ff <= 16'h0000;
      end else begin
         ee_cnt_ff  <= nxt_ee_cnt;
         ee_done_ff <= nxt_ee_done;
         sub_id_ff  <= nxt_sub_id;
         sub_vid_ff <= nxt_sub_vid;
      end
   end

   // timer and line size: each byte lane has its own enable
   always @* begin
      nxt_hold_timer = hold_timer_ff;
      nxt_line_words = line_words_ff;
      if (wr_en && hit_lat) begin
         // timer byte in lane 1
         if (avs_byteenable_i[1]) begin
            nxt_hold_timer = avs_writedata_i[15:8];
         end
         // line size byte in lane 0
         if (avs_byteenable_i[0]) begin
            nxt_line_words = avs_writedata_i[7:0];
         end
      end
   end

   // window bases: only bits 31..7 exist, so the low bits of a write
   // fall away and the windows stay 128-byte aligned
   always @* begin
      nxt_io_base  = io_base_ff;
      nxt_mem_base = mem_base_ff;
      // io window
      if (wr_en && hit_io) begin
         nxt_io_base = (io_base_ff & ~be_mask[31:7])
                     | (avs_writedata_i[31:7] & be_mask[31:7]);
      end
      // memory window
      if (wr_en && hit_mem) begin
         nxt_mem_base = (mem_base_ff & ~be_mask[31:7])
                      | (avs_writedata_i[31:7] & be_mask[31:7]);
      end
   end

   // boot rom base: bits 31..17 and the enable; bits 16..1 are not stored
   always @* begin
      nxt_rom_base = rom_base_ff;
      nxt_rom_en   = rom_en_ff;
      if (wr_en && hit_rom) begin
         nxt_rom_base = (rom_base_ff & ~be_mask[31:17])
                      | (avs_writedata_i[31:17] & be_mask[31:17]);
         // enable bit in lane 0
         if (avs_byteenable_i[0]) begin
            nxt_rom_en = avs_writedata_i[0];
         end
      end
   end

   // stored fields; read-only and reserved places never reach a flop,
   // so a write there simply has no effect
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // power-up values
         hold_timer_ff <= `PCFG_RST_HOLD_TIMER;
         line_words_ff <= `PCFG_RST_LINE_WORDS;
         io_base_ff    <= 25'h0000000;
         mem_base_ff   <= 25'h0000000;
         rom_base_ff   <= 15'h0000;
         rom_en_ff     <= 1'b0;
      end else begin
         hold_timer_ff <= nxt_hold_timer;
         line_words_ff <= nxt_line_words;
         io_base_ff    <= nxt_io_base;
         mem_base_ff   <= nxt_mem_base;
         rom_base_ff   <= nxt_rom_base;
         rom_en_ff     <= nxt_rom_en;
      end
   end

   // read images; reserved fields are tied to zero in one place
   assign lat_view  = {16'h0000, hold_timer_ff, line_words_ff};
   assign io_view   = {io_base_ff, 6'h00, 1'b1};
   assign mem_view  = {mem_base_ff, 7'h00};
   assign sub_view  = {sub_id_ff, sub_vid_ff};
   assign rom_view  = {rom_base_ff, 16'h0000, rom_en_ff};

   // status: bit 2 eeprom loaded, bit 1 end request, bit 0 expired
   assign stat_view = {29'h00000000, ee_done_ff, end_txn_o, bus_hold_expired_o};

   // read mux; unmapped places answer zero
   always @* begin
      case (avs_address_i)
         `PCFG_OFS_LAT_LINE:    nxt_rdata = lat_view;
         `PCFG_OFS_IO_BASE:     nxt_rdata = io_view;
         `PCFG_OFS_MEM_BASE:    nxt_rdata = mem_view;
         `PCFG_OFS_SUBSYS:      nxt_rdata = sub_view;
         `PCFG_OFS_ROM_BASE:    nxt_rdata = rom_view;
         `PCFG_OFS_MASTER_STAT: nxt_rdata = stat_view;
         default:               nxt_rdata = 32'h00000000;
      endcase
   end

   // read data registered, valid with the answer edge; it stands
   // until the next read, so the master may take it late
   // captured only in the first cycle of a read
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (avs_read_i & ~ack_ff) begin
         avs_readdata_o <= nxt_rdata;
      end
   end

   // supported line sizes; other values are stored as written but
   // flagged, and the driver picks the alignment bits from this flag
   always @* begin
      case (line_words_ff)
         `PCFG_LINE_8:  line_ok = 1'b1;
         `PCFG_LINE_16: line_ok = 1'b1;
         `PCFG_LINE_32: line_ok = 1'b1;
         default:       line_ok = 1'b0;
      endcase
   end

   // outputs straight from the flops, except cache_line_ok_o decoded from line_words_ff
   assign cache_line_ok_o           = line_ok;
   assign cache_line_words_o        = line_words_ff;
   assign io_window_base_addr_o     = io_base_ff;
   assign memory_window_base_addr_o = mem_base_ff;
   assign boot_rom_base_addr_o      = rom_base_ff;
   assign boot_rom_en_o             = rom_en_ff;

   // latency timer: loaded from the programmed byte when the master
   // engine raises frame, counts bus clocks while frame is driven,
   // and asks to end the burst once expired and the grant is gone;
   // the grant it sees is the synchronised one
   pcfg_hold_timer #(
      .W (8)
   ) u_timer (
      .clk_i          (clk_i),
      .rst_n_i        (rst_n_i),
      .load_val_i     (hold_timer_ff),
      .frame_start_i  (frame_start_i),
      .frame_active_i (frame_active_i),
      .gnt_active_i   (~gnt_s2_ff),
      .expired_o      (bus_hold_expired_o),
      .end_txn_o      (end_txn_o)
   );
endmodule // pcfg_header_regs

// file: logic/pcfg_hold_timer.v
// master latency timer: counts bus clocks from frame assertion
`timescale 1ns/10ps
module pcfg_hold_timer #(
   parameter W = 8                       // timer width
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] load_val_i,       // programmed timer value
   input  wire         frame_start_i,    // pulse: device asserts frame as master
   input  wire         frame_active_i,   // level: device drives frame
   input  wire         gnt_active_i,     // level: grant held (synchronised)
   output wire         expired_o,        // timer reached zero
   output wire         end_txn_o         // request to end master transaction
);
   reg [W-1:0] cnt_ff;                   // remaining cycles
   reg         run_ff;                   // counting in progress
   reg [W-1:0] nxt_cnt;
   reg         nxt_run;

   // load on frame start, count down while frame driven
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_run = run_ff;
      if (frame_start_i) begin
         nxt_cnt = load_val_i;
         nxt_run = 1'b1;
      end else if (!frame_active_i) begin
         nxt_run = 1'b0;                 // frame gone, stop
      end else if (run_ff && cnt_ff != {W{1'b0}}) begin
         nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_ff <= {W{1'b0}};
         run_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         run_ff <= nxt_run;
      end
   end

   assign expired_o = run_ff && (cnt_ff == {W{1'b0}});
   // expired and grant withdrawn while frame still driven
   assign end_txn_o = expired_o && frame_active_i && !gnt_active_i;
endmodule // pcfg_hold_timer

// file: verification/pcfg_far_end.sv
// far side model: serial eeprom word and bus arbiter grant
`timescale 1ns/10ps
module pcfg_far_end #(
   parameter EE = 32'h5EC01D2E          // arbitrary eeprom word
) (
   input  wire        clk_i,
   input  wire        gnt_off_i,        // bench asks arbiter to withdraw
   output reg         gnt_n_o,
   output wire [31:0] ee_word_o
);
   // eeprom word holds steady, sampled once after reset
   assign ee_word_o = EE;
   // grant pin follows the request one clock late, like a real arbiter
   always @(posedge clk_i) begin
      gnt_n_o <= gnt_off_i;
   end
endmodule // pcfg_far_end

// file: verification/pcfg_header_regs_asserts.sv
// assertion checker for the configuration header bank
`timescale 1ns/10ps
`include "pcfg_map.vh"
module pcfg_chk (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire [7:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_waitrequest_o,
   input wire [31:0] avs_readdata_o,
   input wire        frame_active_i,
   input wire        gnt_n_i,
   input wire [7:0]  cache_line_words_o,
   input wire        cache_line_ok_o,
   input wire [24:0] io_window_base_addr_o,
   input wire [24:0] memory_window_base_addr_o,
   input wire [14:0] boot_rom_base_addr_o,
   input wire        boot_rom_en_o,
   input wire        bus_hold_expired_o,
   input wire        end_txn_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire rd_done = avs_read_i & ~avs_waitrequest_o;  // read answered now
   wire [7:0] a = avs_address_i;
   sequence s_ack; avs_waitrequest_o ##1 !avs_waitrequest_o; endsequence
   property p_wait; $rose(avs_read_i) |-> s_ack; endproperty
   a_wait: assert property (p_wait) else $error("read wait wrong");
   property p_line; cache_line_ok_o == (cache_line_words_o == `PCFG_LINE_8 ||
      cache_line_words_o == `PCFG_LINE_16 || cache_line_words_o == `PCFG_LINE_32); endproperty
   a_line: assert property (p_line) else $error("line ok flag wrong");
   property p_lat; rd_done && a == 8'h0C |->
      avs_readdata_o[31:16] == 16'h0000 && avs_readdata_o[7:0] == cache_line_words_o; endproperty
   a_lat: assert property (p_lat) else $error("timer reg read wrong");
   property p_io; rd_done && a == 8'h10 |->
      avs_readdata_o == {io_window_base_addr_o, 7'h01}; endproperty
   a_io: assert property (p_io) else $error("io base read wrong");
   property p_mem; rd_done && a == 8'h14 |->
      avs_readdata_o == {memory_window_base_addr_o, 7'h00}; endproperty
   a_mem: assert property (p_mem) else $error("mem base read wrong");
   property p_rom; rd_done && a == 8'h30 |->
      avs_readdata_o == {boot_rom_base_addr_o, 16'h0000, boot_rom_en_o}; endproperty
   a_rom: assert property (p_rom) else $error("rom base read wrong");
   property p_end; end_txn_o |-> bus_hold_expired_o && frame_active_i; endproperty
   a_end: assert property (p_end) else $error("end without expiry");
   // grant held low three edges: synchroniser cannot show it removed
   property p_gnt; !gnt_n_i [*3] |-> !end_txn_o; endproperty
   a_gnt: assert property (p_gnt) else $error("end while granted");
endmodule // pcfg_chk
bind pcfg_header_regs pcfg_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
   .frame_active_i(frame_active_i), .gnt_n_i(gnt_n_i),
   .cache_line_words_o(cache_line_words_o), .cache_line_ok_o(cache_line_ok_o),
   .io_window_base_addr_o(io_window_base_addr_o), .boot_rom_en_o(boot_rom_en_o),
   .memory_window_base_addr_o(memory_window_base_addr_o),
   .boot_rom_base_addr_o(boot_rom_base_addr_o),
   .bus_hold_expired_o(bus_hold_expired_o), .end_txn_o(end_txn_o));

// file: verification/tb.sv
// self-checking bench for the configuration header bank
`timescale 1ns/10ps
`include "pcfg_map.vh"
module tb;
   localparam EEW = 32'h5EC01D2E;        // arbitrary eeprom word
   logic clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, fs = 0, fa = 0, goff = 0;
   logic [7:0]  addr = 8'h00, nv;
   logic [31:0] wd = 32'h0, q, x = 32'd48;
   logic [3:0]  be = 4'hF;
   logic [31:0] mdl [0:63];              // model of the register bank
   logic [7:0]  al [0:7] = '{8'h0C, 8'h10, 8'h14, 8'h2C, 8'h30, 8'h08, 8'h3C, 8'hFC};
   wire wq, gnt_n, ok, exp_o, end_o, ren;
   wire [31:0] rdat, ee;
   wire [7:0]  line;
   wire [24:0] iob, mb;
   wire [14:0] rb;
   integer failures = 0, checks_done = 0, i, n;
   pcfg_header_regs #(.EE_LOAD_CYC(4)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_waitrequest_o(wq), .avs_readdata_o(rdat),
      .ee_subsys_i(ee), .frame_start_i(fs), .frame_active_i(fa), .gnt_n_i(gnt_n),
      .cache_line_words_o(line), .cache_line_ok_o(ok), .io_window_base_addr_o(iob),
      .memory_window_base_addr_o(mb), .boot_rom_base_addr_o(rb), .boot_rom_en_o(ren),
      .bus_hold_expired_o(exp_o), .end_txn_o(end_o));
   pcfg_far_end #(.EE(EEW)) far (.clk_i(clk_i), .gnt_off_i(goff), .gnt_n_o(gnt_n),
      .ee_word_o(ee));
   initial forever #2 clk_i = ~clk_i;
   function [31:0] xs(input [31:0] v);
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // writable bits of each place; unmapped and read-only places take none
   function [31:0] wm(input [7:0] a);
      case (a)
         8'h0C:        wm = 32'h0000FFFF;
         8'h10, 8'h14: wm = 32'hFFFFFF80;
         8'h30:        wm = 32'hFFFE0001;
         default:      wm = 32'h0;
      endcase
   endfunction
   function [31:0] ex(input [7:0] a);
      ex = (a == 8'h2C) ? EEW : mdl[a[7:2]] | {31'h0, a == 8'h10};
   endfunction
   task chk(input [31:0] s, input [31:0] e, input string nm);
      checks_done++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task bus(input w, input [7:0] a, input [31:0] d, input [3:0] b);
      integer k;
      logic [31:0] m;
      k = 0;
      addr <= a; wd <= d; be <= b; rd <= !w; wr <= w;
      do begin @(posedge clk_i); k++; end while (wq !== 1'b0 && k < 50);
      q = rdat;
      rd <= 0; wr <= 0;
      if (k >= 50) failures++;
      m = wm(a) & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
      if (w) mdl[a[7:2]] = (mdl[a[7:2]] & ~m) | (d & m);
      @(posedge clk_i);
   endtask
   task stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      for (i = 0; i < 64; i++) mdl[i] = 0;
      mdl[3] = {16'h0, `PCFG_RST_HOLD_TIMER, `PCFG_RST_LINE_WORDS};
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1;
      repeat (8) @(posedge clk_i);
      for (i = 0; i < 8; i++) begin bus(0, al[i], 0, 4'hF); chk(q, ex(al[i]), "reset"); end
      $display("test reset done");
      bus(1, 8'h30, 32'hA5A60001, 4'hF);
      chk({rb, 16'h0, ren}, mdl[12], "rom_first");
      for (i = 0; i < 60; i++) begin
         x = xs(x);
         n = x[2:0];
         bus(1, al[n], xs(x), x[7:4]);
         bus(0, al[n], 0, 4'hF);
         chk(q, ex(al[n]), "readback");
         chk({iob, 7'h00}, mdl[4], "io_out");
         chk({mb, 7'h00}, mdl[5], "mem_out");
         chk({rb, 16'h0, ren}, mdl[12], "rom_out");
      end
      $display("test random done");
      for (i = 0; i < 4; i++) begin
         nv = (i == 3) ? 8'h0C : (8'h08 << i);
         bus(1, 8'h0C, {16'h0, 8'h10, nv}, 4'hF);
         chk({24'h0, line}, {24'h0, nv}, "line");
         chk({31'h0, ok}, {31'h0, i < 3}, "line_ok");
      end
      $display("test line done");
      fs <= 1; fa <= 1;
      @(posedge clk_i);
      fs <= 0; n = 0;
      while (exp_o !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
      chk({31'h0, n >= 14 && n <= 18}, 1, "hold_time");
      chk({31'h0, end_o}, 0, "end_early");
      goff <= 1;
      repeat (4) @(posedge clk_i);
      chk({31'h0, end_o}, 1, "end_txn");
      bus(0, 8'h40, 0, 4'hF);
      chk({29'h0, q[2:0]}, 7, "status");
      fa <= 0; goff <= 0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, end_o}, 0, "end_off");
      $display("test timer done");
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      failures++;
      stop_test;
   end
endmodule // tb
